// file: dv/pmc_ctrl_bench.sv
// Self-checking bench for the power mode controller.
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic por_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, ext_event, gpio_wake, supply_ok;
	logic pll_enable, pll_bypass, core_clock_en, sys_clock_en;
	logic core_power_on, regulator_wake_output, dma_l1_allow;
	logic [15:0] periph_clock_en;
	logic [3:0] vlev_out;
	logic [31:0] rd;
	logic err;
	int n_errors = 0;
	int n_compared = 0;
	// Half period of 2.5 ns gives 200 MHz.
	always #2.5 pclk = ~pclk;
	pmc_ctrl #(.NPERIPH(16)) pmc_ctrl_inst (.pclk(pclk), .presetn(presetn),
		.por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_event(ext_event), .gpio_wake(gpio_wake),
		.pll_enable(pll_enable), .pll_bypass(pll_bypass),
		.core_clock_en(core_clock_en), .sys_clock_en(sys_clock_en),
		.periph_clock_en(periph_clock_en), .core_power_on(core_power_on),
		.regulator_wake_output(regulator_wake_output),
		.vlev_out(vlev_out), .dma_l1_allow(dma_l1_allow));
	pmc_wake_model pmc_wake_model_inst (.pclk(pclk),
		.regulator_wake_output(regulator_wake_output),
		.ext_event(ext_event), .gpio_wake(gpio_wake), .supply_ok(supply_ok));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// One idle edge first, so psel is never assigned twice in a step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_errors++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic wait_on(input logic sys, input logic v);
		int i;
		for (i = 0; i < 20; i++) begin
			edges(1);
			if ((sys ? sys_clock_en : core_clock_en) === v) break;
		end
		if (i == 20) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic rst(input logic por);
		@(posedge pclk);
		presetn <= 1'b0;
		por_n <= ~por;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		edges(2);
	endtask
	task automatic mode(input logic [2:0] req, input logic l1, input logic off);
		apb(1'b1, pmc_pkg::MODE_CTL_OFS, {26'h0, l1, off, 1'b1, req});
		edges(2);
	endtask
	task automatic outs(input logic [5:0] e);
		chk({pll_enable, pll_bypass, core_clock_en, sys_clock_en,
			core_power_on, regulator_wake_output}, e);
	endtask
	task automatic stat(input pmc_pkg::pmc_state_t s);
		apb(1'b0, pmc_pkg::STATUS_OFS, 32'h0);
		chk(rd[4:0], s);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		outs(6'h2F);
		chk(periph_clock_en, 16'hFFFF);
		stat(pmc_pkg::ST_FULL_ON);
		apb(1'b0, pmc_pkg::REG_CTL_OFS, 32'h0);
		chk(rd[4:0], {1'b1, pmc_pkg::VLEV_RST});
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
	endtask
	task automatic t_active();
		mode(pmc_pkg::REQ_ACTIVE, 1'b1, 1'b1);
		outs(6'h1F);
		chk(dma_l1_allow, 1'b1);
		stat(pmc_pkg::ST_ACTIVE);
		mode(pmc_pkg::REQ_ACTIVE, 1'b1, 1'b0);
		outs(6'h3F);
		mode(pmc_pkg::REQ_FULL_ON, 1'b1, 1'b0);
		outs(6'h2F);
		mode(3'h5, 1'b1, 1'b0);
		stat(pmc_pkg::ST_FULL_ON);
	endtask
	task automatic t_sleep();
		mode(pmc_pkg::REQ_SLEEP, 1'b1, 1'b0);
		outs(6'h27);
		chk(dma_l1_allow, 1'b0);
		mode(pmc_pkg::REQ_ACTIVE, 1'b1, 1'b0);
		stat(pmc_pkg::ST_SLEEP);
		pmc_wake_model_inst.raise(1'b0, 8);
		wait_on(1'b0, 1'b1);
		outs(6'h2F);
	endtask
	task automatic t_deep();
		mode(pmc_pkg::REQ_DEEP, 1'b0, 1'b0);
		chk({pll_enable, core_clock_en, sys_clock_en, core_power_on}, 4'h1);
		pmc_wake_model_inst.raise(1'b0, 8);
		edges(3);
		chk(sys_clock_en, 1'b0);
		pmc_wake_model_inst.raise(1'b1, 8);
		wait_on(1'b1, 1'b1);
		outs(6'h2F);
	endtask
	task automatic t_periph();
		apb(1'b1, pmc_pkg::PCLK_EN_OFS, 32'hA5C3);
		edges(2);
		chk(periph_clock_en, 16'hA5C3);
		apb(1'b0, pmc_pkg::PCLK_EN_OFS, 32'h0);
		chk(rd[15:0], 16'hA5C3);
	endtask
	task automatic t_hiber();
		apb(1'b1, pmc_pkg::REG_CTL_OFS, 32'h16);
		edges(2);
		chk(vlev_out, 4'h6);
		outs(6'h2F);
		apb(1'b1, pmc_pkg::REG_CTL_OFS, 32'h06);
		edges(3);
		chk({pll_enable, core_clock_en, sys_clock_en, core_power_on}, 4'h0);
		chk({regulator_wake_output, supply_ok}, 2'h0);
		apb(1'b1, pmc_pkg::REG_CTL_OFS, 32'h16);
		edges(2);
		chk(core_power_on, 1'b0);
		rst(1'b0);
		chk(core_power_on, 1'b1);
		apb(1'b0, pmc_pkg::REG_CTL_OFS, 32'h0);
		chk(rd[4:0], 5'h16);
		apb(1'b1, pmc_pkg::REG_CTL_OFS, 32'h10);
		edges(3);
		chk(core_power_on, 1'b0);
		rst(1'b1);
		apb(1'b0, pmc_pkg::REG_CTL_OFS, 32'h0);
		chk(rd[4:0], {1'b1, pmc_pkg::VLEV_RST});
	endtask
	// Reset is held ten cycles, then every scenario runs in turn.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		edges(2);
		t_reset();
		t_active();
		t_sleep();
		t_deep();
		t_periph();
		t_hiber();
		conclude();
	end
endmodule
`default_nettype wire

// file: dv/pmc_ctrl_checker.sv
// Port assertions for the power mode controller.
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl_checker (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB write.
	input wire logic pready, // APB ready.
	input wire logic ext_event, // Sleep wake.
	input wire logic gpio_wake, // Deep sleep wake.
	input wire logic pll_enable, // PLL on.
	input wire logic pll_bypass, // PLL bypassed.
	input wire logic core_clock_en, // Core gate.
	input wire logic sys_clock_en, // System gate.
	input wire logic core_power_on, // Core supply wanted.
	input wire logic regulator_wake_output, // Regulator request.
	input wire logic [3:0] vlev_out, // Voltage level.
	input wire logic dma_l1_allow // DMA grant.
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Gates hold reset values until one edge after release, so the
	// mode relations other than the hibernate one are only judged from the second edge on.
	logic up_q;
	logic wr;
	assign wr = psel && penable && pwrite && pready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_q <= 1'b0;
		end else begin
			up_q <= 1'b1;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_full_on;
		up_q && core_clock_en && !pll_bypass |-> pll_enable;
	endproperty
	a_full_on: assert property (p_full_on) else $error("PLL off");
	property p_sleep_run;
		up_q && !core_clock_en && sys_clock_en |-> pll_enable && core_power_on;
	endproperty
	a_sleep_run: assert property (p_sleep_run) else $error("sleep");
	property p_sleep_dma;
		up_q && !core_clock_en && sys_clock_en |-> !dma_l1_allow;
	endproperty
	a_sleep_dma: assert property (p_sleep_dma) else $error("dma");
	property p_deep;
		up_q && !sys_clock_en && core_power_on |-> !pll_enable && !core_clock_en;
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep");
	property p_hiber;
		!core_power_on |-> !pll_enable && !core_clock_en && !sys_clock_en;
	endproperty
	a_hiber: assert property (p_hiber) else $error("hibernate");
	// Once the regulator is told to drop the core supply, only a reset
	// may raise the wake line again.
	property p_wake_out;
		!regulator_wake_output |=> !regulator_wake_output;
	endproperty
	a_wake_out: assert property (p_wake_out) else $error("wake pin");
	property p_vlev_zero;
		up_q && vlev_out == 4'h0 |-> ##[0:3] !core_power_on;
	endproperty
	a_vlev_zero: assert property (p_vlev_zero) else $error("zero V");
	property p_sleep_wake;
		up_q && !core_clock_en && sys_clock_en && ext_event |->
			##[1:6] core_clock_en;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("wake");
	property p_deep_wake;
		up_q && !sys_clock_en && core_power_on && gpio_wake |->
			##[1:8] sys_clock_en;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("gpio");
	property p_no_spont;
		$fell(core_clock_en) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
	endproperty
	a_no_spont: assert property (p_no_spont) else $error("stray");
endmodule
bind pmc_ctrl pmc_ctrl_checker pmc_ctrl_checker_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .ext_event(ext_event), .gpio_wake(gpio_wake),
	.pll_enable(pll_enable), .pll_bypass(pll_bypass),
	.core_clock_en(core_clock_en), .sys_clock_en(sys_clock_en),
	.core_power_on(core_power_on),
	.regulator_wake_output(regulator_wake_output),
	.vlev_out(vlev_out), .dma_l1_allow(dma_l1_allow));
`default_nettype wire

// file: dv/pmc_wake_model.sv
// Wake sources and core regulator as seen from the controller's pins.
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_model (
	input wire logic pclk, // Bench clock.
	input wire logic regulator_wake_output, // Power request.
	output logic ext_event, // Sleep wake event.
	output logic gpio_wake, // GPIO wake level.
	output logic supply_ok // Core supply present.
);
	initial begin
		ext_event = 1'b0;
		gpio_wake = 1'b0;
	end
	// The shutdown input is active low, so supply follows the request.
	always @(posedge pclk) begin
		supply_ok <= regulator_wake_output;
	end
	// Holds a wake level; never shorter than the detection minimum.
	task automatic raise(input logic gpio, input int cyc);
		int n;
		n = (cyc < pmc_pkg::WAKE_MIN_CYC) ? pmc_pkg::WAKE_MIN_CYC : cyc;
		@(posedge pclk);
		if (gpio) begin
			gpio_wake <= 1'b1;
		end else begin
			ext_event <= 1'b1;
		end
		repeat (n) @(posedge pclk);
		gpio_wake <= 1'b0;
		ext_event <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: rtl/pmc_clk_gate.sv
// Registered clock-enable gates, one per gated domain.
`timescale 1ns/1ps
`default_nettype none
module pmc_clk_gate #(
	parameter int W = 1
) (
	input wire logic clk, // Controller clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [W-1:0] want, // Requested enable per gate.
	input wire logic [W-1:0] rst_val, // Not used at reset; shape only.
	output logic [W-1:0] en // Glitch-free enable per gate.
);

	// Each enable only moves on a clock edge, so the gated clock never
	// sees a partial pulse; reset leaves every gate closed.
	genvar i;
	for (i = 0; i < W; i++) begin : g_gate
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				en[i] <= 1'b0;
			end else begin
				en[i] <= want[i] | (rst_val[i] & 1'b0);
			end
		end
	end

endmodule
`default_nettype wire

// file: rtl/pmc_ctrl.sv
// Power mode controller top: state machine, clock gates, APB registers.
`timescale 1ns/1ps
`default_nettype none

module pmc_ctrl #(
	parameter int NPERIPH = 16
) (
	input wire logic pclk, // Controller clock, 200 MHz.
	input wire logic presetn, // Reset, active low.
	input wire logic por_n, // Power-on reset of the I/O domain.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic ext_event, // Asynchronous sleep wake event.
	input wire logic gpio_wake, // Asynchronous GPIO wake level.
	output logic pll_enable, // PLL powered.
	output logic pll_bypass, // PLL bypassed, reference clock used.
	output logic core_clock_en, // Core clock gate enable.
	output logic sys_clock_en, // System clock gate enable.
	output logic [NPERIPH-1:0] periph_clock_en, // Peripheral gates.
	output logic core_power_on, // Core supply wanted.
	output logic regulator_wake_output, // High while core power wanted.
	output logic [3:0] vlev_out, // Requested core voltage level.
	output logic dma_l1_allow // System DMA to L1 may be granted.
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pmc_pkg::pmc_state_t state_q, state_d;
	pmc_pkg::pmc_state_t ret_q;
	logic [2:0] req_q;
	logic go_q;
	logic pll_off_q;
	logic l1_dma_q;
	logic [NPERIPH-1:0] pclk_en_q;
	logic [3:0] vlev_q;
	logic pwr_keep_q;
	logic ev_s, gw_s;
	logic [2:0] wake_cnt_q;
	logic wake_ok;
	logic ev_ok;
	logic wr, rd_hit;
	logic hib_req;
	logic [NPERIPH+1:0] gate_want, gate_en;

	// Decode a byte address into a register hit.
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	pmc_sync #(
		.W(2)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({ext_event, gpio_wake}),
		.q({ev_s, gw_s})
	);

	// The GPIO level must stand long enough to be a real wake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cnt_q <= 3'h0;
		end else if (!gw_s) begin
			wake_cnt_q <= 3'h0;
		end else if (wake_cnt_q < 3'(pmc_pkg::WAKE_MIN_CYC)) begin
			wake_cnt_q <= wake_cnt_q + 3'h1;
		end
	end

	assign wake_ok = (wake_cnt_q >= 3'(pmc_pkg::WAKE_MIN_CYC));
	assign ev_ok = ev_s | wake_ok;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; the access phase always completes at once.
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd_hit = hit(paddr, pmc_pkg::MODE_CTL_OFS) |
		hit(paddr, pmc_pkg::STATUS_OFS) |
		hit(paddr, pmc_pkg::PCLK_EN_OFS) |
		hit(paddr, pmc_pkg::REG_CTL_OFS);
	assign pslverr = psel & penable & ~rd_hit;

	// Read mux; reserved bits read as zero.
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit(paddr, pmc_pkg::MODE_CTL_OFS)) begin
			prdata[pmc_pkg::MODE_REQ_LSB +: pmc_pkg::MODE_REQ_W] = req_q;
			prdata[pmc_pkg::PLL_OFF_BIT] = pll_off_q;
			prdata[pmc_pkg::L1_DMA_BIT] = l1_dma_q;
		end else if (hit(paddr, pmc_pkg::STATUS_OFS)) begin
			prdata[4:0] = state_q;
			prdata[8] = pll_enable;
			prdata[9] = pll_bypass;
			prdata[10] = core_clock_en;
			prdata[11] = sys_clock_en;
			prdata[12] = core_power_on;
		end else if (hit(paddr, pmc_pkg::PCLK_EN_OFS)) begin
			prdata[NPERIPH-1:0] = pclk_en_q;
		end else if (hit(paddr, pmc_pkg::REG_CTL_OFS)) begin
			prdata[pmc_pkg::VLEV_LSB +: pmc_pkg::VLEV_W] = vlev_q;
			prdata[pmc_pkg::PWR_KEEP_BIT] = pwr_keep_q;
		end
	end

	// ----------------------------------------------------------------
	// Mode control register
	// ----------------------------------------------------------------
	// Hibernate loses this register, so entering it clears the fields.
	// The go bit is a one-cycle request consumed by the state machine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_q <= pmc_pkg::REQ_FULL_ON;
			pll_off_q <= 1'b0;
			l1_dma_q <= 1'b0;
			go_q <= 1'b0;
		end else if (state_q == pmc_pkg::ST_HIBER) begin
			req_q <= pmc_pkg::REQ_FULL_ON;
			pll_off_q <= 1'b0;
			l1_dma_q <= 1'b0;
			go_q <= 1'b0;
		end else if (wr && hit(paddr, pmc_pkg::MODE_CTL_OFS)) begin
			req_q <= pwdata[pmc_pkg::MODE_REQ_LSB +: pmc_pkg::MODE_REQ_W];
			pll_off_q <= pwdata[pmc_pkg::PLL_OFF_BIT];
			l1_dma_q <= pwdata[pmc_pkg::L1_DMA_BIT];
			go_q <= pwdata[pmc_pkg::MODE_GO_BIT];
		end else begin
			go_q <= 1'b0;
		end
	end

	// Peripheral gate enables; all on after reset, lost in hibernate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pclk_en_q <= pmc_pkg::PCLK_EN_RST[NPERIPH-1:0];
		end else if (state_q == pmc_pkg::ST_HIBER) begin
			pclk_en_q <= '0;
		end else if (wr && hit(paddr, pmc_pkg::PCLK_EN_OFS)) begin
			pclk_en_q <= pwdata[NPERIPH-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Regulator control register
	// ----------------------------------------------------------------
	// The level sits in the I/O supply domain: only power-on resets it to VLEV_RST,
	// so it survives hibernate and the reset that ends it.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			vlev_q <= pmc_pkg::VLEV_RST;
		end else if (wr && hit(paddr, pmc_pkg::REG_CTL_OFS)) begin
			vlev_q <= pwdata[pmc_pkg::VLEV_LSB +: pmc_pkg::VLEV_W];
		end
	end

	// The power keep bit is forced back on by reset, which is how a
	// reset wakes the regulator out of hibernate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_keep_q <= 1'b1;
		end else if (wr && hit(paddr, pmc_pkg::REG_CTL_OFS)) begin
			pwr_keep_q <= pwdata[pmc_pkg::PWR_KEEP_BIT];
		end
	end

	// A zero level or a cleared keep bit asks for hibernate.
	assign hib_req = (vlev_q == pmc_pkg::VLEV_OFF) | ~pwr_keep_q;

	// ----------------------------------------------------------------
	// Operating state machine
	// ----------------------------------------------------------------
	// Requests are taken only while the core runs; sleeping states
	// leave only on their wake events, hibernate only on reset.
	always_comb begin
		state_d = state_q;
		case (state_q)
			pmc_pkg::ST_FULL_ON,
			pmc_pkg::ST_ACTIVE: begin
				if (hib_req) begin
					state_d = pmc_pkg::ST_HIBER;
				end else if (go_q) begin
					case (req_q)
						pmc_pkg::REQ_FULL_ON: state_d = pmc_pkg::ST_FULL_ON;
						pmc_pkg::REQ_ACTIVE: state_d = pmc_pkg::ST_ACTIVE;
						pmc_pkg::REQ_SLEEP: state_d = pmc_pkg::ST_SLEEP;
						pmc_pkg::REQ_DEEP: state_d = pmc_pkg::ST_DEEP;
						default: state_d = state_q;
					endcase
				end
			end
			pmc_pkg::ST_SLEEP: begin
				if (ev_ok) begin
					state_d = ret_q;
				end
			end
			pmc_pkg::ST_DEEP: begin
				if (wake_ok) begin
					state_d = ret_q;
				end
			end
			pmc_pkg::ST_HIBER: begin
				state_d = pmc_pkg::ST_HIBER;
			end
			default: begin
				state_d = pmc_pkg::ST_FULL_ON;
			end
		endcase
	end

	// State register; reset lands in full-on with no software help.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= pmc_pkg::ST_FULL_ON;
		end else begin
			state_q <= state_d;
		end
	end

	// Remember which running state to resume after a wake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ret_q <= pmc_pkg::ST_FULL_ON;
		end else if (state_q == pmc_pkg::ST_FULL_ON ||
			state_q == pmc_pkg::ST_ACTIVE) begin
			ret_q <= state_q;
		end
	end

	// ----------------------------------------------------------------
	// Settings per state
	// ----------------------------------------------------------------
	// PLL and bypass are registered so they never glitch on a change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_enable <= 1'b1;
			pll_bypass <= 1'b0;
		end else begin
			case (state_d)
				pmc_pkg::ST_FULL_ON: begin
					pll_enable <= 1'b1;
					pll_bypass <= 1'b0;
				end
				pmc_pkg::ST_ACTIVE: begin
					// Bypass routes the reference clock to core and bus.
					pll_enable <= ~pll_off_q;
					pll_bypass <= 1'b1;
				end
				pmc_pkg::ST_SLEEP: begin
					pll_enable <= 1'b1;
					pll_bypass <= pll_bypass;
				end
				pmc_pkg::ST_DEEP: begin
					pll_enable <= 1'b0;
					pll_bypass <= pll_bypass;
				end
				default: begin
					pll_enable <= 1'b0;
					pll_bypass <= pll_bypass;
				end
			endcase
		end
	end

	// Power and DMA permission follow the state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_power_on <= 1'b1;
			dma_l1_allow <= 1'b0;
		end else begin
			core_power_on <= (state_d != pmc_pkg::ST_HIBER);
			dma_l1_allow <= l1_dma_q &
				(state_d == pmc_pkg::ST_FULL_ON ||
				state_d == pmc_pkg::ST_ACTIVE);
		end
	end

	// Wake output to the regulator: high while core power is wanted.
	assign regulator_wake_output = core_power_on;
	assign vlev_out = vlev_q;

	// ----------------------------------------------------------------
	// Clock gates
	// ----------------------------------------------------------------
	// Peripheral gates open only while the system clock runs.
	always_comb begin
		gate_want[0] = (state_d == pmc_pkg::ST_FULL_ON) |
			(state_d == pmc_pkg::ST_ACTIVE);
		gate_want[1] = gate_want[0] |
			(state_d == pmc_pkg::ST_SLEEP);
		gate_want[NPERIPH+1:2] = pclk_en_q & {NPERIPH{gate_want[1]}};
	end

	pmc_clk_gate #(
		.W(NPERIPH + 2)
	) u_gate (
		.clk(pclk),
		.rst_n(presetn),
		.want(gate_want),
		.rst_val('0),
		.en(gate_en)
	);

	assign core_clock_en = gate_en[0];
	assign sys_clock_en = gate_en[1];
	assign periph_clock_en = gate_en[NPERIPH+1:2];

endmodule
`default_nettype wire

// file: rtl/pmc_pkg.sv
// Package of constants and types for the power mode controller.
`default_nettype none
package pmc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the APB bus).
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_CTL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] PCLK_EN_OFS = 8'h08;
	localparam logic [7:0] REG_CTL_OFS = 8'h0C;

	// ----------------------------------------------------------------
	// Mode control fields.
	// ----------------------------------------------------------------
	localparam int MODE_REQ_LSB = 0;
	localparam int MODE_REQ_W = 3;
	localparam int MODE_GO_BIT = 3;
	localparam int PLL_OFF_BIT = 4;
	localparam int L1_DMA_BIT = 5;

	// Mode request codes written to the request field.
	localparam logic [2:0] REQ_FULL_ON = 3'h0;
	localparam logic [2:0] REQ_ACTIVE = 3'h1;
	localparam logic [2:0] REQ_SLEEP = 3'h2;
	localparam logic [2:0] REQ_DEEP = 3'h3;

	// ----------------------------------------------------------------
	// Regulator control fields and reset values.
	// ----------------------------------------------------------------
	localparam int VLEV_LSB = 0;
	localparam int VLEV_W = 4;
	localparam int PWR_KEEP_BIT = 4;
	localparam logic [3:0] VLEV_RST = 4'hB;
	localparam logic [3:0] VLEV_OFF = 4'h0;
	localparam logic [31:0] PCLK_EN_RST = 32'hFFFF_FFFF;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int WAKE_MIN_NS = 10;
	localparam int WAKE_MIN_CYC =
		(WAKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Operating states, one-hot.
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_FULL_ON = 5'b00001,
		ST_ACTIVE = 5'b00010,
		ST_SLEEP = 5'b00100,
		ST_DEEP = 5'b01000,
		ST_HIBER = 5'b10000
	} pmc_state_t;

endpackage
`default_nettype wire

// file: rtl/pmc_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Destination clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [W-1:0] d, // Asynchronous input levels.
	output logic [W-1:0] q // Synchronised levels.
);

	logic [W-1:0] meta_q;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule
`default_nettype wire
